//--- verilog/vtc_regs.sv
// Even/odd field timing control registers and the decoder soft reset register.
// Assumes host accesses are one-cycle strobes synchronous to the pixel clock;
// read data appears one cycle after the read strobe.
// Assumes the luma comb bits are held in a register outside this block.
`timescale 1ns/10ps
module vtc_regs #(
  parameter bit ENHANCED = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Host register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Video timing inputs
  input wire logic line_start,
  input wire logic field_odd,
  input wire logic luma_comb_enable_even,
  input wire logic luma_comb_enable_odd,
  // Decoder outputs
  output logic horizontal_reset_output,
  output logic [2:0] vertical_filter_taps,
  output logic filter_interp,
  output logic software_reset_strobe
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] even_ff, nxt_even_ff; // Even field copy
  logic [7:0] odd_ff, nxt_odd_ff; // Odd field copy
  logic srst_ff, nxt_srst_ff; // Soft reset pulse
  logic [7:0] rdata_ff, nxt_rdata_ff; // Host read data
  logic [2:0] taps_ff, nxt_taps_ff; // Applied tap count
  logic interp_ff, nxt_interp_ff; // Applied interpolation
  logic [7:0] sel_vtc; // Copy for the current field
  logic sel_comb; // Comb setting for the current field
  logic [1:0] sel_code; // Filter code in use
  logic srst_hit; // Write to the soft reset address

  // Field selection
  always_comb begin
    sel_vtc = field_odd ? odd_ff : even_ff;
    sel_comb = field_odd ? luma_comb_enable_odd : luma_comb_enable_even;
    sel_code = sel_vtc[vtc_pkg::VTC_FILT_MSB:vtc_pkg::VTC_FILT_LSB];
    // Reset address hit, whatever the data
    srst_hit = reg_wr && (reg_addr == vtc_pkg::VTC_DECODER_SOFT_RESET_OFS);
  end

  // Register writes, soft reset and reads
  always_comb begin
    nxt_even_ff = even_ff;
    nxt_odd_ff = odd_ff;
    nxt_rdata_ff = rdata_ff;
    // Accepted in any state of the decoder
    nxt_srst_ff = srst_hit;
    if (srst_ff) begin
      // Reset outranks a write landing in the same cycle
      nxt_even_ff = vtc_pkg::VTC_RESET_VAL;
      nxt_odd_ff = vtc_pkg::VTC_RESET_VAL;
    end else if (reg_wr) begin
      // Reserved bits stored as written; software keeps them zero
      if (reg_addr == vtc_pkg::VTC_EVEN_OFS) begin
        nxt_even_ff = reg_wdata;
      end
      if (reg_addr == vtc_pkg::VTC_ODD_OFS) begin
        nxt_odd_ff = reg_wdata;
      end
    end
    if (reg_rd) begin
      // Read data is a host bus register, soft reset leaves it alone
      unique case (reg_addr)
        vtc_pkg::VTC_EVEN_OFS: begin
          nxt_rdata_ff = even_ff;
        end
        vtc_pkg::VTC_ODD_OFS: begin
          nxt_rdata_ff = odd_ff;
        end
        vtc_pkg::VTC_DECODER_SOFT_RESET_OFS: begin
          nxt_rdata_ff = vtc_pkg::VTC_DECODER_SOFT_RESET_RD;
        end
        default: begin
          // Unmapped address reads as zero
          nxt_rdata_ff = 8'h00;
        end
      endcase
    end
  end

  // Vertical filter selection
  // Outputs follow the field and comb inputs one edge later
  always_comb begin
    nxt_taps_ff = vtc_pkg::vtc_avg_taps(sel_code, sel_comb);
    nxt_interp_ff = !sel_comb;
  end

  // Registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      // Power-on defaults
      even_ff <= vtc_pkg::VTC_RESET_VAL;
      odd_ff <= vtc_pkg::VTC_RESET_VAL;
      srst_ff <= 1'b0;
      rdata_ff <= 8'h00;
      taps_ff <= 3'h0;
      interp_ff <= 1'b0;
    end else begin
      even_ff <= nxt_even_ff;
      odd_ff <= nxt_odd_ff;
      srst_ff <= nxt_srst_ff;
      rdata_ff <= nxt_rdata_ff;
      taps_ff <= nxt_taps_ff;
      interp_ff <= nxt_interp_ff;
    end
  end

  // ----------------------------------------------------------------
  // Horizontal reset pulse
  // ----------------------------------------------------------------
  // Width select taken from the copy of the current field
  vtc_horizontal_reset_output_gen #(
    .ENHANCED(ENHANCED)
  ) u_horizontal_reset_output (
    .clock(clock),
    .rst(rst),
    .line_start(line_start),
    .width_select(sel_vtc[vtc_pkg::VTC_HSEL_BIT]),
    .soft_reset(srst_ff),
    .horizontal_reset_output(horizontal_reset_output)
  );

  // Outputs straight from their flops
  assign reg_rdata = rdata_ff;
  assign vertical_filter_taps = taps_ff;
  assign filter_interp = interp_ff;
  assign software_reset_strobe = srst_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking vtc_cb @(posedge clock); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Soft reset checks
  // ----------------------------------------------------------------
  // Every write to the reset address raises the strobe
  chk_srst_any_time: assert property (
    srst_hit |=> srst_ff)
    else $error("soft reset write not accepted");
  // Strobe only follows a reset write
  chk_srst_one_cycle: assert property (
    srst_ff |-> $past(srst_hit))
    else $error("soft reset pulse without a write");
  // Both copies back to defaults
  chk_srst_defaults: assert property (
    srst_ff |=> even_ff == vtc_pkg::VTC_RESET_VAL && odd_ff == vtc_pkg::VTC_RESET_VAL)
    else $error("soft reset did not restore defaults");
  // Reset address reads the fixed value
  chk_srst_read: assert property (
    reg_rd && reg_addr == vtc_pkg::VTC_DECODER_SOFT_RESET_OFS |=> reg_rdata == vtc_pkg::VTC_DECODER_SOFT_RESET_RD)
    else $error("soft reset register read value wrong");
  // Running reset pulse dropped by the decoder reset
  chk_srst_hr_low: assert property (
    srst_ff |=> !horizontal_reset_output)
    else $error("soft reset left the reset pulse running");

  // ----------------------------------------------------------------
  // Field copy checks
  // ----------------------------------------------------------------
  // Writes land in one copy only
  chk_even_copy: assert property (
    reg_wr && reg_addr == vtc_pkg::VTC_EVEN_OFS && !srst_ff
      |=> even_ff == $past(reg_wdata) && $stable(odd_ff))
    else $error("even field write wrong");
  chk_odd_copy: assert property (
    reg_wr && reg_addr == vtc_pkg::VTC_ODD_OFS && !srst_ff
      |=> odd_ff == $past(reg_wdata) && $stable(even_ff))
    else $error("odd field write wrong");
  // Reads return the addressed copy
  chk_even_read: assert property (
    reg_rd && reg_addr == vtc_pkg::VTC_EVEN_OFS |=> reg_rdata == $past(even_ff))
    else $error("even field read wrong");
  chk_odd_read: assert property (
    reg_rd && reg_addr == vtc_pkg::VTC_ODD_OFS |=> reg_rdata == $past(odd_ff))
    else $error("odd field read wrong");
  // Bus read data untouched without a read, soft reset included
  chk_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  // ----------------------------------------------------------------
  // Filter selection checks
  // ----------------------------------------------------------------
  // Tap count and interpolation per comb setting
  chk_comb_taps: assert property (
    sel_comb |=> vertical_filter_taps == {1'b0, $past(sel_code)} + 3'h2 && !filter_interp)
    else $error("comb filter taps wrong");
  chk_interp_taps: assert property (
    !sel_comb |=> filter_interp
      && vertical_filter_taps == ($past(sel_code) == 2'h0 ? 3'h0 : {1'b0, $past(sel_code)} + 3'h1))
    else $error("interpolating filter taps wrong");
  // Odd field applies the odd copy
  chk_filt_field: assert property (
    field_odd && odd_ff[1:0] == 2'h3 && luma_comb_enable_odd |=> vertical_filter_taps == 3'h5)
    else $error("odd field filter code not applied");
  // Even field code 00 with comb on gives the two-tap average
  chk_even_field: assert property (
    !field_odd && even_ff[1:0] == 2'h0 && luma_comb_enable_even
      |=> vertical_filter_taps == 3'h2)
    else $error("even field filter code not applied");

  // ----------------------------------------------------------------
  // Coverage of the main scenarios
  // ----------------------------------------------------------------
  cov_srst: cover property (srst_hit ##1 srst_ff);
  cov_five_tap: cover property (vertical_filter_taps == 3'h5);
  cov_odd_write: cover property (reg_wr && reg_addr == vtc_pkg::VTC_ODD_OFS);

endmodule : vtc_regs

//--- verilog/vtc_pkg.sv
// Constants shared by the field timing control bank and its reset pulse shaper.
// Assumes a single pixel clock domain and byte-wide memory-mapped register accesses.
// Operation
// - Select bit clear: reset pulse 64 pixel clocks
// - Original variant, select set: one-pixel pulse
// - Enhanced variant, select set: 32-clock pulse
// - Two-bit field picks vertical filter taps
// - Comb on: binomial filters of 2..5 taps
// - Comb off: interpolation plus 0,2,3,4 taps
// - Reset register writable at any moment
// - Any reset write restores decoder defaults
// - Reset register read value is meaningless
// - Separate even and odd timing copies
package vtc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] VTC_EVEN_OFS = 8'h6C; // Even field timing control
  localparam logic [7:0] VTC_ODD_OFS = 8'hEC; // Odd field timing control
  localparam logic [7:0] VTC_DECODER_SOFT_RESET_OFS = 8'h7C; // Decoder soft reset
  localparam logic [7:0] VTC_RESET_VAL = 8'h00; // Timing control default
  localparam logic [7:0] VTC_DECODER_SOFT_RESET_RD = 8'h00; // Value shown on soft reset reads

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int VTC_HSEL_BIT = 7; // Reset width select
  localparam int VTC_FILT_LSB = 0; // Filter code low bit
  localparam int VTC_FILT_MSB = 1; // Filter code high bit

  // ----------------------------------------------------------------
  // Pulse widths in pixel clocks
  // ----------------------------------------------------------------
  localparam logic [6:0] VTC_HR_STD_CYC = 7'h40; // 64 cycles
  localparam logic [6:0] VTC_HR_ENH_CYC = 7'h20; // 32 cycles
  localparam logic [6:0] VTC_HR_ORIG_CYC = 7'h01; // One pixel

  // Binomial tap count for a filter code and comb setting
  function automatic logic [2:0] vtc_avg_taps(input logic [1:0] code, input logic comb);
    logic [2:0] taps;
    taps = 3'h0;
    if (comb) begin
      taps = {1'b0, code} + 3'h2;
    end else if (code != 2'h0) begin
      taps = {1'b0, code} + 3'h1;
    end
    return taps;
  endfunction : vtc_avg_taps

  // Chosen pulse width for a select bit and variant
  function automatic logic [6:0] vtc_hr_width(input logic sel, input logic enhanced);
    logic [6:0] w;
    w = VTC_HR_STD_CYC;
    if (sel) begin
      w = enhanced ? VTC_HR_ENH_CYC : VTC_HR_ORIG_CYC;
    end
    return w;
  endfunction : vtc_hr_width

endpackage : vtc_pkg

//--- verilog/vtc_horizontal_reset_output_gen.sv
// Horizontal reset pulse shaper, started once per line.
// Assumes line_start is a one-cycle pulse synchronous to the pixel clock.
`timescale 1ns/10ps
module vtc_horizontal_reset_output_gen #(
  parameter bit ENHANCED = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic line_start,
  input wire logic width_select,
  input wire logic soft_reset,
  // Pulse out
  output logic horizontal_reset_output
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic {VTC_HR_IDLE, VTC_HR_PULSE} vtc_hr_state_t;
  vtc_hr_state_t state_ff, nxt_state_ff; // Pulse state
  logic [6:0] cnt_ff, nxt_cnt_ff; // Remaining high cycles minus one
  logic hr_ff, nxt_hr_ff; // Output flop
  logic sel_ff, nxt_sel_ff; // Select latched at pulse start
  logic [6:0] len_ff, nxt_len_ff; // Helper: observed high length

  // Next-state logic
  always_comb begin
    nxt_state_ff = state_ff;
    nxt_cnt_ff = cnt_ff;
    nxt_hr_ff = hr_ff;
    nxt_sel_ff = sel_ff;
    nxt_len_ff = hr_ff ? len_ff + 7'h01 : 7'h00;
    if (soft_reset) begin
      // Decoder reset aborts any pulse
      nxt_state_ff = VTC_HR_IDLE;
      nxt_hr_ff = 1'b0;
      nxt_cnt_ff = 7'h00;
    end else begin
      unique case (state_ff)
        VTC_HR_IDLE: begin
          if (line_start) begin
            // Width fixed for the whole pulse
            nxt_cnt_ff = vtc_pkg::vtc_hr_width(width_select, ENHANCED) - 7'h01;
            nxt_sel_ff = width_select;
            nxt_hr_ff = 1'b1;
            nxt_state_ff = VTC_HR_PULSE;
          end
        end
        VTC_HR_PULSE: begin
          if (cnt_ff == 7'h00) begin
            // Last high cycle done
            nxt_hr_ff = 1'b0;
            nxt_state_ff = VTC_HR_IDLE;
          end else begin
            nxt_cnt_ff = cnt_ff - 7'h01;
          end
        end
      endcase
    end
  end

  // Registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= VTC_HR_IDLE;
      cnt_ff <= 7'h00;
      hr_ff <= 1'b0;
      sel_ff <= 1'b0;
      len_ff <= 7'h00;
    end else begin
      state_ff <= nxt_state_ff;
      cnt_ff <= nxt_cnt_ff;
      hr_ff <= nxt_hr_ff;
      sel_ff <= nxt_sel_ff;
      len_ff <= nxt_len_ff;
    end
  end

  assign horizontal_reset_output = hr_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking vtc_hr_cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_hr_std_width: assert property (
    $fell(hr_ff) && !$past(soft_reset) && !sel_ff |-> len_ff == vtc_pkg::VTC_HR_STD_CYC)
    else $error("standard reset pulse width wrong");
  chk_hr_orig_width: assert property (
    !ENHANCED && $fell(hr_ff) && !$past(soft_reset) && sel_ff
      |-> len_ff == vtc_pkg::VTC_HR_ORIG_CYC)
    else $error("one-pixel reset pulse width wrong");
  chk_hr_enh_width: assert property (
    ENHANCED && $fell(hr_ff) && !$past(soft_reset) && sel_ff
      |-> len_ff == vtc_pkg::VTC_HR_ENH_CYC)
    else $error("enhanced short reset pulse width wrong");
  cov_hr_long: cover property ($fell(hr_ff) && len_ff == vtc_pkg::VTC_HR_STD_CYC);
  cov_hr_short: cover property ($fell(hr_ff) && sel_ff);

endmodule : vtc_horizontal_reset_output_gen

//--- sim/tb.sv
// Self-checking bench for the field timing control bank and its soft reset.
// Runs the enhanced and the original variant side by side; inputs change at the falling edge.
`timescale 1ns/10ps
module tb;
  // ----------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------
  localparam logic [7:0] EV = vtc_pkg::VTC_EVEN_OFS; // Even copy address
  localparam logic [7:0] OD = vtc_pkg::VTC_ODD_OFS; // Odd copy address
  localparam logic [7:0] SR = vtc_pkg::VTC_DECODER_SOFT_RESET_OFS; // Soft reset address
  logic clock = 1'b0; // Pixel clock
  logic rst = 1'b1; // Async reset
  logic reg_wr = 1'b0; // Write strobe
  logic reg_rd = 1'b0; // Read strobe
  logic [7:0] reg_addr = 8'h00; // Byte address
  logic [7:0] reg_wdata = 8'h00; // Write data
  logic [7:0] reg_rdata; // Read data
  logic line_start = 1'b0; // Line pulse
  logic field_odd = 1'b0; // Field in use
  logic luma_comb_enable_even = 1'b0; // Comb bit, even field
  logic luma_comb_enable_odd = 1'b0; // Comb bit, odd field
  logic horizontal_reset_output; // Reset pulse
  logic hr_orig; // Reset pulse, original variant
  logic [2:0] vertical_filter_taps; // Tap count
  logic filter_interp; // Interpolation flag
  logic software_reset_strobe; // Soft reset pulse
  int fails = 0; // Mismatches
  int total_checks = 0; // Comparisons
  int cycles = 0; // Hang guard
  int strobe_cnt = 0; // Soft reset pulses seen

  always #5 clock = ~clock;

  vtc_regs #(.ENHANCED(1'b1)) dut_u (
    .clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .line_start(line_start), .field_odd(field_odd),
    .luma_comb_enable_even(luma_comb_enable_even),
    .luma_comb_enable_odd(luma_comb_enable_odd),
    .horizontal_reset_output(horizontal_reset_output),
    .vertical_filter_taps(vertical_filter_taps), .filter_interp(filter_interp),
    .software_reset_strobe(software_reset_strobe)
  );

  // Original variant on the same stimulus; only its reset pulse is compared
  vtc_regs #(.ENHANCED(1'b0)) dut_orig_u (
    .clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(),
    .line_start(line_start), .field_odd(field_odd),
    .luma_comb_enable_even(luma_comb_enable_even),
    .luma_comb_enable_odd(luma_comb_enable_odd),
    .horizontal_reset_output(hr_orig),
    .vertical_filter_taps(), .filter_interp(),
    .software_reset_strobe()
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask : wr

  // One-cycle read strobe, data compared once settled
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd = 1'b0;
    @(negedge clock);
    chk(reg_rdata, exp);
  endtask : rd_chk

  // Launch a line and count the cycles each variant's reset pulse stays high
  task automatic hpulse(output logic [7:0] n, output logic [7:0] m);
    int w;
    n = 8'h00;
    m = 8'h00;
    @(negedge clock);
    line_start = 1'b1;
    @(negedge clock);
    line_start = 1'b0;
    for (w = 0; w < 4 && horizontal_reset_output !== 1'b1; w++) @(negedge clock);
    for (w = 0; w < 200 && (horizontal_reset_output === 1'b1 || hr_orig === 1'b1); w++) begin
      if (horizontal_reset_output === 1'b1) n++;
      if (hr_orig === 1'b1) m++;
      @(negedge clock);
    end
  endtask : hpulse

  // Expected {interp, taps} for a filter code and comb bit
  function automatic logic [3:0] exp_filt(input logic [1:0] c, input logic comb);
    if (comb) return {2'b00, c} + 4'h2;
    return (c == 2'h0) ? 4'h8 : ({2'b10, c} + 4'h1);
  endfunction : exp_filt

  // ----------------------------------------------------------------
  // Monitors and hang guard
  // ----------------------------------------------------------------
  // Count strobe cycles at settled points
  always @(negedge clock) begin
    if (software_reset_strobe === 1'b1) strobe_cnt++;
  end

  // Cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] n;
    logic [7:0] m;
    int k;
    int base;
    repeat (8) @(negedge clock);
    rst = 1'b0;
    // Defaults after reset
    rd_chk(EV, 8'h00);
    rd_chk(OD, 8'h00);
    chk({4'h0, filter_interp, vertical_filter_taps}, 8'h08);
    // Two independent copies
    wr(EV, 8'h02);
    wr(OD, 8'h81);
    rd_chk(EV, 8'h02);
    rd_chk(OD, 8'h81);
    // Every code, both comb settings, both fields; other copy differs except for code 1 in the even field and code 3 in the odd field
    // Picture taken as scaled below 193 active pixels, so every code is legal
    for (k = 0; k < 16; k++) begin
      field_odd = k[3];
      luma_comb_enable_even = k[2];
      luma_comb_enable_odd = k[2];
      wr(k[3] ? OD : EV, {6'h00, k[1:0]});
      repeat (2) @(negedge clock);
      chk({4'h0, filter_interp, vertical_filter_taps}, {4'h0, exp_filt(k[1:0], k[2])});
    end
    // Pulse widths; odd copy (bit 7 clear) governs odd fields; comb off again
    field_odd = 1'b0;
    luma_comb_enable_even = 1'b0;
    luma_comb_enable_odd = 1'b0;
    wr(EV, 8'h00);
    hpulse(n, m);
    chk(n, 8'h40);
    chk(m, 8'h40);
    wr(EV, 8'h80);
    hpulse(n, m);
    chk(n, 8'h20);
    chk(m, 8'h01);
    field_odd = 1'b1;
    hpulse(n, m);
    chk(n, 8'h40);
    chk(m, 8'h40);
    // Soft reset in mid-pulse
    field_odd = 1'b0;
    @(negedge clock);
    line_start = 1'b1;
    @(negedge clock);
    line_start = 1'b0;
    repeat (4) @(negedge clock);
    chk({7'h00, horizontal_reset_output}, 8'h01);
    base = strobe_cnt;
    wr(SR, 8'hA5);
    repeat (3) @(negedge clock);
    chk(8'(strobe_cnt - base), 8'h01);
    chk({7'h00, horizontal_reset_output}, 8'h00);
    rd_chk(EV, 8'h00);
    rd_chk(OD, 8'h00);
    chk({4'h0, filter_interp, vertical_filter_taps}, 8'h08);
    // Zero data resets as well
    wr(OD, 8'h83);
    wr(SR, 8'h00);
    repeat (2) @(negedge clock);
    rd_chk(OD, 8'h00);
    // Timing write right behind a reset write is lost, reset wins
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = SR;
    @(negedge clock);
    reg_addr = EV;
    reg_wdata = 8'h81;
    @(negedge clock);
    reg_wr = 1'b0;
    rd_chk(EV, 8'h00);
    // Reset register reads back the fixed value
    rd_chk(SR, vtc_pkg::VTC_DECODER_SOFT_RESET_RD);
    summarize();
  end
endmodule : tb
